//--- src/flash_loader_cfg.svh
// Function
// R1 - enter update only on reset release with entry pin low, else run user program
// R2 - steps run strictly: entry, check byte, erase, data write, checksum
// R3 - host sends the link check byte after forcing entry
// R4 - after entry wait without timeout for exactly one received byte
// R5 - check byte is 0xBA; match continues, mismatch requests a reset
// R6 - erase all main flash right after a correct check byte
// R7 - rewrite reset vector to loader entry right after erase
// R8 - allow about 16 ms per erased segment
// R9 - accept data byte by byte, no flow control or acknowledge
// R10 - host sends main flash size minus 2 data bytes
// R11 - program consecutive addresses upward from lowest, never the reset vector word
// R12 - host sends XOR of all data bytes after the last one
// R13 - XOR over bytes actually written, compare with received checksum
// R14 - send 0xF8 on match, 0xFE on mismatch
// R15 - serial framing 9600 baud, 8 data bits, 1 stop, no parity
// R16 - only receive and transmit lines, timer based bit timing
// R17 - loader region separate, 254 bytes, never erased
// R18 - after the answer stay idle until next reset
`ifndef FLASH_LOADER_CFG_SVH
`define FLASH_LOADER_CFG_SVH
`define CLK_HZ 200000000
`define BAUD 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD)
`define HALF_CYCLES (`BIT_CYCLES / 2)
`define SYNC_BYTE 8'hBA
`define ACK_BYTE 8'hF8
`define NACK_BYTE 8'hFE
`define MAIN_BASE 16'hFE00
`define MAIN_BYTES 16'h0200
`define MAIN_SEGMENTS 16'h0001
`define VECTOR_ADDR 16'hFFFE
`define LOADER_ENTRY 16'h1000
`define LOADER_BYTES 16'h00FE
`define ERASE_MS_PER_SEG 16
`define ERASE_CYCLES_PER_SEG (`ERASE_MS_PER_SEG * (`CLK_HZ / 1000))
`endif

//--- src/flash_loader_pkg.sv
`default_nettype none
package flash_loader_pkg;
   typedef enum logic [3:0]
   {
      st_entry = 4'h0,
      st_sync = 4'h1,
      st_erase = 4'h3,
      st_erase_wait = 4'h2,
      st_vec_lo = 4'h6,
      st_vec_hi = 4'h7,
      st_data = 4'h5,
      st_wr_wait = 4'h4,
      st_csum = 4'hc,
      st_reply = 4'hd,
      st_idle = 4'hf,
      st_user = 4'he,
      st_reset = 4'ha
   } loader_state_e;
   typedef struct packed
   {
      logic erase;
      logic write;
      logic [15:0] addr;
      logic [7:0] data;
   } flash_cmd_s;
endpackage
`default_nettype wire

//--- src/uart_core.sv
`default_nettype none
`include "flash_loader_cfg.svh"
module uart_core
   import flash_loader_pkg::*;
#(
   // cycles per bit; the bench shortens it so that a whole image fits in one run
   parameter int unsigned BIT_LEN = `BIT_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // receive
   input wire logic rxd,
   input wire logic rx_en,
   output logic [7:0] rx_data,
   output logic rx_valid,
   // transmit
   input wire logic [7:0] tx_data,
   input wire logic tx_start,
   output logic tx_busy,
   output logic txd
);
   logic [15:0] rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
   logic [3:0] rbit_r, rbit_nxt, tbit_r, tbit_nxt;
   logic [7:0] rsh_r, rsh_nxt;
   logic [9:0] tsh_r, tsh_nxt;
   logic rbusy_r, rbusy_nxt, rv_r, rv_nxt, tb_r, tb_nxt;
   // bit timing from a cycle counter; no handshake lines exist [R16]
   always_comb
   begin
      rcnt_nxt = rcnt_r;
      rbit_nxt = rbit_r;
      rsh_nxt = rsh_r;
      rbusy_nxt = rbusy_r;
      rv_nxt = 1'b0;
      if (!rbusy_r)
      begin
         if (rx_en && !rxd)
         begin
            rbusy_nxt = 1'b1;
            rcnt_nxt = 16'(BIT_LEN / 2);
            rbit_nxt = 4'h0;
         end
      end
      else if (rcnt_r != 16'h0000)
         rcnt_nxt = rcnt_r - 16'h0001;
      else
      begin
         rcnt_nxt = 16'(BIT_LEN - 1);
         rbit_nxt = rbit_r + 4'h1;
         // start, 8 data lsb first, stop; no parity [R15]
         if (rbit_r == 4'h0 && rxd)
            rbusy_nxt = 1'b0;
         else if (rbit_r >= 4'h1 && rbit_r <= 4'h8)
            rsh_nxt = {rxd, rsh_r[7:1]};
         else if (rbit_r == 4'h9)
         begin
            rbusy_nxt = 1'b0;
            rv_nxt = rxd;
         end
      end
   end
   always_comb
   begin
      tcnt_nxt = tcnt_r;
      tbit_nxt = tbit_r;
      tsh_nxt = tsh_r;
      tb_nxt = tb_r;
      if (!tb_r)
      begin
         if (tx_start)
         begin
            tb_nxt = 1'b1;
            tsh_nxt = {1'b1, tx_data, 1'b0};
            tcnt_nxt = 16'(BIT_LEN - 1);
            tbit_nxt = 4'h0;
         end
      end
      else if (tcnt_r != 16'h0000)
         tcnt_nxt = tcnt_r - 16'h0001;
      else
      begin
         tcnt_nxt = 16'(BIT_LEN - 1);
         tsh_nxt = {1'b1, tsh_r[9:1]};
         tbit_nxt = tbit_r + 4'h1;
         if (tbit_r == 4'h9)
            tb_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rcnt_r <= 16'h0000;
         rbit_r <= 4'h0;
         rsh_r <= 8'h00;
         rbusy_r <= 1'b0;
         rv_r <= 1'b0;
         tcnt_r <= 16'h0000;
         tbit_r <= 4'h0;
         tsh_r <= 10'h3ff;
         tb_r <= 1'b0;
      end
      else
      begin
         rcnt_r <= rcnt_nxt;
         rbit_r <= rbit_nxt;
         rsh_r <= rsh_nxt;
         rbusy_r <= rbusy_nxt;
         rv_r <= rv_nxt;
         tcnt_r <= tcnt_nxt;
         tbit_r <= tbit_nxt;
         tsh_r <= tsh_nxt;
         tb_r <= tb_nxt;
      end
   end
   assign rx_data = rsh_r;
   assign rx_valid = rv_r;
   assign tx_busy = tb_r;
   assign txd = tb_r ? tsh_r[0] : 1'b1;
   frame_len_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(tb_r) |-> tb_r [*8] ##1 tb_r) // [R15]
      else $error("transmit frame ended too early");
endmodule
`default_nettype wire

//--- src/flash_update_loader.sv
`default_nettype none
`include "flash_loader_cfg.svh"
module flash_update_loader
   import flash_loader_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES_PER_SEG * `MAIN_SEGMENTS,
   parameter int unsigned BIT_LEN = `BIT_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // entry strap
   input wire logic entry_pin,
   // serial link
   input wire logic rxd,
   output logic txd,
   // flash controller
   output flash_cmd_s flash_cmd,
   input wire logic flash_busy,
   // system
   output logic run_user,
   output logic sys_reset_req
);
   loader_state_e st_r, st_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0] csum_r, csum_nxt, txb_r, txb_nxt;
   logic [31:0] wait_r, wait_nxt;
   logic txgo_r, txgo_nxt, user_r, user_nxt, rst_r, rst_nxt;
   flash_cmd_s cmd_r, cmd_nxt;
   logic [7:0] rx_data;
   logic rx_valid, tx_busy, utxd, txd_r;
   uart_core #(.BIT_LEN(BIT_LEN)) u_uart
   (
      .clk(clk),
      .rstn(rstn),
      .rxd(rxd),
      .rx_en(st_r == st_sync || st_r == st_data || st_r == st_wr_wait || st_r == st_csum),
      .rx_data(rx_data),
      .rx_valid(rx_valid),
      .tx_data(txb_r),
      .tx_start(txgo_r),
      .tx_busy(tx_busy),
      .txd(utxd)
   );
   // loader code sits outside main flash and is never addressed by erase or write [R17]
   function automatic logic in_main(input logic [15:0] a);
      in_main = (a >= `MAIN_BASE) && (a < `VECTOR_ADDR);
   endfunction
   always_comb
   begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      csum_nxt = csum_r;
      txb_nxt = txb_r;
      wait_nxt = wait_r;
      txgo_nxt = 1'b0;
      user_nxt = user_r;
      rst_nxt = rst_r;
      cmd_nxt = cmd_r;
      cmd_nxt.erase = 1'b0;
      cmd_nxt.write = 1'b0;
      // fixed order of states, no path skips a step [R2]
      case (st_r)
         st_entry:
         begin
            // strap sampled on first clock after reset release [R1]
            if (!entry_pin)
               st_nxt = st_sync;
            else
            begin
               st_nxt = st_user;
               user_nxt = 1'b1;
            end
         end
         st_sync:
         begin
            // no timeout while waiting for the check byte [R4]
            if (rx_valid)
            begin
               if (rx_data == `SYNC_BYTE) // [R5]
               begin
                  st_nxt = st_erase;
                  cmd_nxt.erase = 1'b1; // [R6]
                  cmd_nxt.addr = `MAIN_BASE;
                  wait_nxt = ERASE_CYCLES;
               end
               else
               begin
                  st_nxt = st_reset;
                  rst_nxt = 1'b1;
               end
            end
         end
         st_erase:
            st_nxt = st_erase_wait;
         st_erase_wait:
         begin
            // fixed time budget per segment, also waits for the flash itself [R8]
            if (wait_r != 32'h0)
               wait_nxt = wait_r - 32'h1;
            else if (!flash_busy)
            begin
               st_nxt = st_vec_lo;
               cmd_nxt.write = 1'b1; // [R7]
               cmd_nxt.addr = `VECTOR_ADDR;
               cmd_nxt.data = 8'(`LOADER_ENTRY & 16'h00ff);
            end
         end
         st_vec_lo:
            if (!flash_busy && !cmd_r.write)
            begin
               st_nxt = st_vec_hi;
               cmd_nxt.write = 1'b1; // [R7]
               cmd_nxt.addr = `VECTOR_ADDR + 16'h0001;
               cmd_nxt.data = 8'(`LOADER_ENTRY >> 8);
            end
         st_vec_hi:
            if (!flash_busy && !cmd_r.write)
            begin
               st_nxt = st_data;
               addr_nxt = `MAIN_BASE;
               csum_nxt = 8'h00;
            end
         st_data, st_wr_wait:
         begin
            // bytes taken as they come, nothing echoed [R9]
            if (rx_valid && in_main(addr_r))
            begin
               cmd_nxt.write = 1'b1; // [R11]
               cmd_nxt.addr = addr_r;
               cmd_nxt.data = rx_data;
               csum_nxt = csum_r ^ rx_data; // [R13]
               addr_nxt = addr_r + 16'h0001;
               // host sends size minus 2 bytes, then the checksum [R10]
               if (addr_r + 16'h0001 == `VECTOR_ADDR)
                  st_nxt = st_csum;
               else
                  st_nxt = st_wr_wait;
            end
         end
         st_csum:
            if (rx_valid)
            begin
               // received byte is the host xor of all data [R12]
               txb_nxt = (rx_data == csum_r) ? `ACK_BYTE : `NACK_BYTE; // [R14]
               txgo_nxt = 1'b1;
               st_nxt = st_reply;
            end
         st_reply:
            if (!txgo_r && !tx_busy)
               st_nxt = st_idle;
         st_idle, st_user, st_reset:
            // stays here until the next reset [R18]
            st_nxt = st_r;
         default:
            st_nxt = st_entry;
      endcase
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_r <= st_entry;
         addr_r <= 16'h0000;
         csum_r <= 8'h00;
         txb_r <= 8'h00;
         wait_r <= 32'h0;
         txgo_r <= 1'b0;
         user_r <= 1'b0;
         rst_r <= 1'b0;
         cmd_r <= '0;
         txd_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         csum_r <= csum_nxt;
         txb_r <= txb_nxt;
         wait_r <= wait_nxt;
         txgo_r <= txgo_nxt;
         user_r <= user_nxt;
         rst_r <= rst_nxt;
         cmd_r <= cmd_nxt;
         // silent line once answered [R18]
         txd_r <= (st_r == st_idle) ? 1'b1 : utxd;
      end
   end
   assign flash_cmd = cmd_r;
   assign txd = txd_r;
   assign run_user = user_r;
   assign sys_reset_req = rst_r;
   entry_low_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_entry && !entry_pin) |=> st_r == st_sync) // [R1]
      else $error("entry pin low did not start update");
   bad_sync_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_sync && rx_valid && rx_data != `SYNC_BYTE) |=> sys_reset_req) // [R5]
      else $error("wrong check byte without reset");
   erase_first_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_sync && rx_valid && rx_data == `SYNC_BYTE) |=> cmd_r.erase) // [R6]
      else $error("erase not issued after check byte");
   vector_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_vec_lo && $changed(st_r)) |-> cmd_r.write && cmd_r.addr == `VECTOR_ADDR) // [R7]
      else $error("reset vector not rewritten");
   no_vec_data_a: assert property (@(posedge clk) disable iff (!rstn)
      (cmd_r.write && $past(st_r) inside {st_data, st_wr_wait}) |-> cmd_r.addr < `VECTOR_ADDR) // [R11]
      else $error("data written over reset vector");
   reply_code_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_csum && rx_valid) |=> txgo_r && (txb_r == `ACK_BYTE || txb_r == `NACK_BYTE)) // [R14]
      else $error("answer byte not sent");
   idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_idle) |=> st_r == st_idle && !cmd_r.write && !cmd_r.erase) // [R18]
      else $error("activity after answer");
   user_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      run_user |-> !cmd_r.write && !cmd_r.erase ##1 run_user) // [R2]
      else $error("user run touched flash");
   ack_match_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_csum && rx_valid && rx_data == csum_r) |=> txb_r == `ACK_BYTE) // [R14]
      else $error("matching checksum not acknowledged");
   nack_miss_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == st_csum && rx_valid && rx_data != csum_r) |=> txb_r == `NACK_BYTE) // [R14]
      else $error("wrong checksum not rejected");
   data_step_a: assert property (@(posedge clk) disable iff (!rstn)
      (cmd_r.write && $past(st_r) inside {st_data, st_wr_wait}) |-> cmd_r.addr == addr_r - 16'h0001) // [R11]
      else $error("data address not consecutive");
endmodule
`default_nettype wire

//--- testbench/host_uart_model.sv
`default_nettype none
`include "flash_loader_cfg.svh"
module host_uart_model
#(
   parameter int unsigned BIT_LEN = `BIT_CYCLES
)
(
   // clock
   input wire logic clk,
   // serial lines towards and from the loader
   output logic rxd,
   input wire logic txd
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle high between frames, no handshake lines at all
   initial rxd = 1'b1;

   // one 8n1 frame, lsb first, timed by clock counts
   // used for the check byte, data bytes and checksum
   task automatic send(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(negedge clk);
         rxd = frame[i];
         repeat (BIT_LEN - 1) @(negedge clk);
      end
   endtask

   // catches one answer frame, sampling each bit in its middle
   task automatic recv(output logic [7:0] b);
      int n;
      b = 8'h00;
      n = 0;
      while (txd !== 1'b0 && n < 40 * BIT_LEN)
      begin
         @(negedge clk);
         n++;
      end
      repeat (BIT_LEN / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_LEN) @(negedge clk);
         b[i] = txd;
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/uart_flash_update_loader_bench.sv
`default_nettype none
`include "flash_loader_cfg.svh"
module uart_flash_update_loader_bench;
   import flash_loader_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned ERASE_SIM = 100;
   // short bit time so two full images fit; each image is about 41000 cycles
   localparam int unsigned BIT_SIM = 8;
   localparam int unsigned LIMIT = 95000;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic entry_pin = 1'b1;
   logic rxd;
   logic txd;
   logic flash_busy = 1'b0;
   logic run_user;
   logic sys_reset_req;
   flash_cmd_s flash_cmd;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_erase = 0;
   int t_erase = 0;
   logic [15:0] wr_addr[$];
   logic [15:0] wr_data[$];
   int t_wr[$];

   always #2.5 clk = ~clk;

   host_uart_model #(.BIT_LEN(BIT_SIM)) i_host (.clk(clk), .rxd(rxd), .txd(txd));

   flash_update_loader #(.ERASE_CYCLES(ERASE_SIM), .BIT_LEN(BIT_SIM)) i_dut
   (
      .clk(clk),
      .rstn(rstn),
      .entry_pin(entry_pin),
      .rxd(rxd),
      .txd(txd),
      .flash_cmd(flash_cmd),
      .flash_busy(flash_busy),
      .run_user(run_user),
      .sys_reset_req(sys_reset_req)
   );

   // flash command log; the cycle stamps let the erase wait be judged
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (flash_cmd.erase === 1'b1)
      begin
         n_erase <= n_erase + 1;
         t_erase <= cyc;
      end
      if (flash_cmd.write === 1'b1)
      begin
         wr_addr.push_back(flash_cmd.addr);
         wr_data.push_back({8'h00, flash_cmd.data});
         t_wr.push_back(cyc);
      end
      if (cyc == LIMIT)
      begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // reset held 12 cycles, entry strap set before release
   task automatic do_reset(input logic pin);
      @(negedge clk);
      rstn = 1'b0;
      entry_pin = pin;
      repeat (12) @(negedge clk);
      wr_addr.delete();
      wr_data.delete();
      t_wr.delete();
      n_erase = 0;
      rstn = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // strap high: user program runs, loader stays silent
   task automatic t_user_run();
      do_reset(1'b1);
      repeat (20) @(negedge clk);
      check({15'h0000, run_user}, 16'h0001);
      check({15'h0000, sys_reset_req}, 16'h0000);
      check(16'(n_erase), 16'h0000);
      check({15'h0000, txd}, 16'h0001);
   endtask

   // wrong check byte after a long silent wait: reset request, no erase
   task automatic t_bad_sync();
      do_reset(1'b0);
      repeat (3000) @(negedge clk);
      check({15'h0000, sys_reset_req}, 16'h0000);
      check({15'h0000, run_user}, 16'h0000);
      i_host.send(8'h55);
      for (int i = 0; i < 50 && sys_reset_req !== 1'b1; i++) @(negedge clk);
      check({15'h0000, sys_reset_req}, 16'h0001);
      check(16'(n_erase), 16'h0000);
      check({15'h0000, txd}, 16'h0001);
   endtask

   // good check byte: erase, vector restore, then data from the bottom up
   task automatic t_update();
      do_reset(1'b0);
      i_host.send(`SYNC_BYTE);
      repeat (ERASE_SIM + 100) @(negedge clk);
      check(16'(n_erase), 16'h0001);
      check(16'(wr_addr.size()), 16'h0002);
      if (wr_addr.size() == 2)
      begin
         check(wr_addr[0], `VECTOR_ADDR);
         check(wr_data[0], 16'(`LOADER_ENTRY & 16'h00ff));
         check(wr_addr[1], `VECTOR_ADDR + 16'h0001);
         check(wr_data[1], 16'(`LOADER_ENTRY >> 8));
         check(16'(t_wr[0] - t_erase >= ERASE_SIM), 16'h0001);
      end
      i_host.send(8'h3c);
      i_host.send(8'ha5);
      repeat (10) @(negedge clk);
      check(16'(wr_addr.size()), 16'h0004);
      if (wr_addr.size() == 4)
      begin
         check(wr_addr[2], `MAIN_BASE);
         check(wr_data[2], 16'h003c);
         check(wr_addr[3], `MAIN_BASE + 16'h0001);
         check(wr_data[3], 16'h00a5);
      end
      check({15'h0000, txd}, 16'h0001);
      check({15'h0000, sys_reset_req}, 16'h0000);
   endtask

   // full image of size minus 2 bytes, then the xor; answer caught as it is sent
   task automatic load_image(input logic bad, output logic [7:0] reply);
      logic [7:0] b;
      logic [7:0] x;
      x = 8'h00;
      do_reset(1'b0);
      i_host.send(`SYNC_BYTE);
      repeat (ERASE_SIM + 100) @(negedge clk);
      for (int i = 0; i < int'(`VECTOR_ADDR - `MAIN_BASE); i++)
      begin
         b = 8'(i * 7 + 3);
         x = x ^ b;
         i_host.send(b);
      end
      fork
         i_host.send(bad ? ~x : x);
         i_host.recv(reply);
      join
   endtask

   // good checksum: accept byte, whole main flash written, then silence
   task automatic t_ack();
      logic [7:0] reply;
      load_image(1'b0, reply);
      check(16'(reply), 16'(`ACK_BYTE));
      check(16'(wr_addr.size()), 16'h0200);
      check(wr_addr[wr_addr.size() - 1], `VECTOR_ADDR - 16'h0001);
      check(wr_data[wr_addr.size() - 1], 16'h00ee);
      i_host.send(8'h11);
      repeat (20) @(negedge clk);
      check(16'(wr_addr.size()), 16'h0200);
      check({15'h0000, txd}, 16'h0001);
   endtask

   // wrong checksum: reject byte
   task automatic t_nack();
      logic [7:0] reply;
      load_image(1'b1, reply);
      check(16'(reply), 16'(`NACK_BYTE));
      check({15'h0000, sys_reset_req}, 16'h0000);
   endtask

   task automatic print_verdict();
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      t_user_run();
      t_bad_sync();
      t_update();
      t_ack();
      t_nack();
      print_verdict();
   end
endmodule
`default_nettype wire
